// >>> lisi_pkg.sv
// shared constants and types for the line interface status and interrupt block
package lisi_pkg;

  // register offsets on the 8-bit host port
  localparam logic [7:0] LISI_OFS_INFO = 8'h11; // line_info_realtime
  localparam logic [7:0] LISI_OFS_STATUS = 8'h16; // line_status_one
  localparam logic [7:0] LISI_OFS_MASK = 8'h17; // line_irq_mask_one

  // reset values
  localparam logic [7:0] LISI_INFO_RST = 8'h00;
  localparam logic [7:0] LISI_STATUS_RST = 8'h00;
  localparam logic [7:0] LISI_MASK_RST = 8'h00;
  localparam logic [7:0] LISI_UNMAPPED_RD = 8'h00;

  // receive level codes
  localparam logic [3:0] LISI_LVL_T1_LIMITED_MAX = 4'h5; // band ending at -15 dB
  localparam logic [3:0] LISI_LVL_E1_LIMITED_MAX = 4'hf; // no narrower span known for e1

  // pattern synchronizer figures
  localparam logic [5:0] LISI_SYNC_MATCH_LAST = 6'h1f; // 32nd matching bit
  localparam logic [5:0] LISI_SYNC_WIN_LAST = 6'h3f; // 64-bit error window
  localparam logic [2:0] LISI_SYNC_ERR_LAST = 3'h5; // sixth error drops sync

  // core clock and derived counts
  localparam int LISI_CLK_PERIOD_NS = 10;
  localparam int LISI_T1_CHAN_NS = 5181; // 8 bits at 1.544 MHz
  localparam int LISI_E1_CHAN_NS = 3906; // 8 bits at 2.048 MHz
  localparam logic [9:0] LISI_T1_CHAN_CYC = 10'(LISI_T1_CHAN_NS / LISI_CLK_PERIOD_NS);
  localparam logic [9:0] LISI_E1_CHAN_CYC = 10'(LISI_E1_CHAN_NS / LISI_CLK_PERIOD_NS);
  localparam int LISI_INPUT_BELOW_THRESHOLD_MS = 50;
  localparam logic [22:0] LISI_INPUT_BELOW_THRESHOLD_CYC = 23'(LISI_INPUT_BELOW_THRESHOLD_MS * 1000000 / LISI_CLK_PERIOD_NS);

  // timer intervals counted in receive bit ticks
  localparam int LISI_T1_RATE_HZ = 1544000;
  localparam int LISI_E1_RATE_HZ = 2048000;
  localparam logic [20:0] LISI_T1_LONG_TICKS = 21'(LISI_T1_RATE_HZ);
  localparam logic [20:0] LISI_T1_SHORT_TICKS = 21'(LISI_T1_RATE_HZ / 1000 * 42);
  localparam logic [20:0] LISI_E1_LONG_TICKS = 21'(LISI_E1_RATE_HZ);
  // multiply first: dividing first truncates 204.8 and would give a short interval
  localparam logic [20:0] LISI_E1_SHORT_TICKS = 21'(LISI_E1_RATE_HZ * 625 / 10000);

  // line_status_one and line_irq_mask_one layout, msb first
  typedef struct packed {
    logic input_below_threshold;
    logic timer_event;
    logic signaling_change_event;
    logic jitter_fifo_near_limit;
    logic rx_carrier_lost;
    logic tx_current_limit_hit;
    logic tx_open_circuit;
    logic tx_clock_lost;
  } lisi_status_t;

  // line_info_realtime layout, msb first
  typedef struct packed {
    logic pattern_sync_live;
    logic bitcode_seen;
    logic tx_current_limit_hit;
    logic tx_open_circuit;
    logic [3:0] rx_level_code;
  } lisi_info_t;

  // static configuration from the control registers elsewhere
  typedef struct packed {
    logic eq_gain_limit;
    logic line_standard_select; // 0 = t1, 1 = e1
    logic counter_interval_select; // 0 = 1 s, 1 = short interval
    logic [3:0] level_threshold;
  } lisi_cfg_t;

  typedef enum logic [1:0] {
    LISI_HUNT = 2'b00,
    LISI_SYNC = 2'b01
  } lisi_sync_t;

endpackage : lisi_pkg

// >>> lisi_top.sv
// line interface status, real-time information and interrupt mask logic
`timescale 1ns/1ps
module lisi_top
  import lisi_pkg::*;
#(
  parameter logic [22:0] INPUT_BELOW_THRESHOLD_CYC = LISI_INPUT_BELOW_THRESHOLD_CYC,
  parameter logic [20:0] T1_LONG_TICKS = LISI_T1_LONG_TICKS,
  parameter logic [20:0] T1_SHORT_TICKS = LISI_T1_SHORT_TICKS,
  parameter logic [20:0] E1_LONG_TICKS = LISI_E1_LONG_TICKS,
  parameter logic [20:0] E1_SHORT_TICKS = LISI_E1_SHORT_TICKS
)
(
  input wire logic core_clk_i, // 100 MHz core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [7:0] addr_i, // host register address
  input wire logic rd_i, // host read strobe, one cycle
  input wire logic wr_i, // host write strobe, one cycle
  input wire logic [7:0] wdata_i, // host write data
  output logic [7:0] rdata_o, // host read data, held until next read
  output logic int_n_o, // interrupt, active low
  input wire lisi_cfg_t cfg_i, // line configuration
  input wire logic [3:0] rx_level_raw_i, // detector level code, full span
  input wire logic tx_open_circuit_i, // transmit outputs open
  input wire logic tx_current_limit_hit_i, // current limiter active
  input wire logic bitcode_seen_i, // bit-code detector sees valid code
  input wire logic bert_bit_valid_i, // one received pattern bit
  input wire logic bert_bit_err_i, // that bit mismatched
  input wire logic liu_tx_clock_in_i, // transmit clock, sampled
  input wire logic rx_carrier_lost_i, // carrier loss detector
  input wire logic jitter_fifo_near_limit_i, // fifo within 4 bits of limit
  input wire logic rx_bit_tick_i, // one pulse per receive clock bit
  input wire logic [31:0] sig_change_i, // per-channel signaling change pulses
  input wire logic [31:0] sig_change_enable_i // per-channel change enables
);

  lisi_info_t info;
  lisi_status_t status;
  lisi_status_t next_status;
  lisi_status_t mask;
  lisi_status_t cond;
  lisi_status_t cond_q;
  lisi_status_t set_bits;
  lisi_sync_t sync_state;
  logic [5:0] match_cnt;
  logic [5:0] win_cnt;
  logic [2:0] err_cnt;
  logic [3:0] level_cap;
  logic [3:0] level_code;
  logic tclk_q;
  logic [9:0] tclk_cnt;
  logic [9:0] chan_cyc;
  logic tx_clock_lost;
  logic [20:0] tmr_cnt;
  logic [20:0] tmr_last;
  logic timer_hit;
  logic [22:0] input_below_threshold_cnt;
  logic input_below_threshold_cond;
  logic below_thr;
  logic rd_status;

  // level code is capped by the gain-limit span, so a weak t1 line reads as -15 dB
  always_comb
  begin
    level_cap = cfg_i.line_standard_select ? LISI_LVL_E1_LIMITED_MAX : LISI_LVL_T1_LIMITED_MAX;
    level_code = rx_level_raw_i;
    if (cfg_i.eq_gain_limit && (rx_level_raw_i > level_cap))
    begin
      level_code = level_cap;
    end
  end

  // real-time information byte, not latched
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      info <= lisi_info_t'(LISI_INFO_RST);
    end
    else
    begin
      info.rx_level_code <= level_code;
      info.tx_open_circuit <= tx_open_circuit_i;
      info.tx_current_limit_hit <= tx_current_limit_hit_i;
      info.bitcode_seen <= bitcode_seen_i;
      info.pattern_sync_live <= (sync_state == LISI_SYNC);
    end
  end

  // pattern synchronizer: hunt for 32 clean bits, then watch 64-bit error windows
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_state <= LISI_HUNT;
      match_cnt <= 6'h00;
      win_cnt <= 6'h00;
      err_cnt <= 3'h0;
    end
    else if (bert_bit_valid_i)
    begin
      case (sync_state)
        LISI_HUNT:
        begin
          win_cnt <= 6'h00;
          err_cnt <= 3'h0;
          if (bert_bit_err_i)
          begin
            match_cnt <= 6'h00;
          end
          else if (match_cnt == LISI_SYNC_MATCH_LAST)
          begin
            match_cnt <= 6'h00;
            sync_state <= LISI_SYNC;
          end
          else
          begin
            match_cnt <= match_cnt + 6'h01;
          end
        end
        LISI_SYNC:
        begin
          win_cnt <= win_cnt + 6'h01;
          if (bert_bit_err_i && (err_cnt == LISI_SYNC_ERR_LAST))
          begin
            sync_state <= LISI_HUNT;
          end
          else if (win_cnt == LISI_SYNC_WIN_LAST)
          begin
            // the last bit of a window still counts, as the first of the next
            err_cnt <= {2'b00, bert_bit_err_i};
          end
          else
          begin
            err_cnt <= err_cnt + {2'b00, bert_bit_err_i};
          end
        end
        default:
        begin
          sync_state <= LISI_HUNT;
        end
      endcase
    end
  end

  // transmit clock watchdog; a channel time is eight line bits at the selected rate
  assign chan_cyc = cfg_i.line_standard_select ? LISI_E1_CHAN_CYC : LISI_T1_CHAN_CYC;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tclk_q <= 1'b0;
      tclk_cnt <= 10'h000;
      tx_clock_lost <= 1'b0;
    end
    else
    begin
      tclk_q <= liu_tx_clock_in_i;
      if (tclk_q != liu_tx_clock_in_i)
      begin
        tclk_cnt <= 10'h000;
        tx_clock_lost <= 1'b0;
      end
      else if (tclk_cnt == chan_cyc - 10'h001)
      begin
        tx_clock_lost <= 1'b1;
      end
      else
      begin
        tclk_cnt <= tclk_cnt + 10'h001;
      end
    end
  end

  // error-counter interval timer, paced by receive bit ticks
  always_comb
  begin
    if (cfg_i.line_standard_select)
    begin
      tmr_last = cfg_i.counter_interval_select ? E1_SHORT_TICKS : E1_LONG_TICKS;
    end
    else
    begin
      tmr_last = cfg_i.counter_interval_select ? T1_SHORT_TICKS : T1_LONG_TICKS;
    end
  end
  assign timer_hit = rx_bit_tick_i && (tmr_cnt >= tmr_last - 21'h000001);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_cnt <= 21'h000000;
    end
    else if (timer_hit)
    begin
      tmr_cnt <= 21'h000000;
    end
    else if (rx_bit_tick_i)
    begin
      tmr_cnt <= tmr_cnt + 21'h000001;
    end
  end

  // under-threshold qualifier; a larger code is a weaker signal
  assign below_thr = level_code > cfg_i.level_threshold;
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      input_below_threshold_cnt <= 23'h000000;
      input_below_threshold_cond <= 1'b0;
    end
    else if (!below_thr)
    begin
      input_below_threshold_cnt <= 23'h000000;
      input_below_threshold_cond <= 1'b0;
    end
    else if (input_below_threshold_cnt == INPUT_BELOW_THRESHOLD_CYC - 23'h000001)
    begin
      input_below_threshold_cond <= 1'b1;
    end
    else
    begin
      input_below_threshold_cnt <= input_below_threshold_cnt + 23'h000001;
    end
  end

  // condition levels feeding the double-interrupt bits
  always_comb
  begin
    cond = '0;
    cond.input_below_threshold = input_below_threshold_cond;
    cond.rx_carrier_lost = rx_carrier_lost_i;
    cond.tx_current_limit_hit = tx_current_limit_hit_i;
    cond.tx_open_circuit = tx_open_circuit_i;
    cond.tx_clock_lost = tx_clock_lost;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cond_q <= '0;
    end
    else
    begin
      cond_q <= cond;
    end
  end

  // sources that set latched bits; conditions on either edge, events once
  always_comb
  begin
    set_bits = cond ^ cond_q;
    set_bits.jitter_fifo_near_limit = jitter_fifo_near_limit_i;
    set_bits.signaling_change_event = |(sig_change_i & sig_change_enable_i);
    set_bits.timer_event = timer_hit;
  end

  // a read clears the status byte, but a set in the same cycle is kept
  assign rd_status = rd_i && (addr_i == LISI_OFS_STATUS);
  always_comb
  begin
    next_status = rd_status ? lisi_status_t'(LISI_STATUS_RST) : status;
    next_status = next_status | set_bits;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status <= lisi_status_t'(LISI_STATUS_RST);
    end
    else
    begin
      status <= next_status;
    end
  end

  // mask register, the only writable byte here
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mask <= lisi_status_t'(LISI_MASK_RST);
    end
    else if (wr_i && (addr_i == LISI_OFS_MASK))
    begin
      mask <= lisi_status_t'(wdata_i);
    end
  end

  // read data; registered so the port sees a stable byte after the strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= LISI_UNMAPPED_RD;
    end
    else if (rd_i)
    begin
      case (addr_i)
        LISI_OFS_INFO: rdata_o <= info;
        LISI_OFS_STATUS: rdata_o <= status;
        LISI_OFS_MASK: rdata_o <= mask;
        default: rdata_o <= LISI_UNMAPPED_RD;
      endcase
    end
  end

  // interrupt pin from the latched, unmasked status
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      int_n_o <= 1'b1;
    end
    else
    begin
      int_n_o <= ~|(next_status & mask);
    end
  end

  sequence hunt_done_s;
    (sync_state == LISI_HUNT) && bert_bit_valid_i && !bert_bit_err_i
      && (match_cnt == LISI_SYNC_MATCH_LAST);
  endsequence

  sequence sixth_err_s;
    (sync_state == LISI_SYNC) && bert_bit_valid_i && bert_bit_err_i
      && (err_cnt == LISI_SYNC_ERR_LAST);
  endsequence

  level_cap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (cfg_i.eq_gain_limit && !cfg_i.line_standard_select && rx_level_raw_i > 4'h5)
      |=> (info.rx_level_code == 4'h5))
    else $error("t1 limited level not capped at -15 dB band");

  sync_gain_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    hunt_done_s |=> ##1 info.pattern_sync_live)
    else $error("sync not reported after 32 matches");

  sync_loss_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sixth_err_s |=> (sync_state == LISI_HUNT) ##1 !info.pattern_sync_live)
    else $error("sync not dropped at sixth error");

  tclk_loss_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (tclk_cnt == chan_cyc - 10'h001 && tclk_q == liu_tx_clock_in_i) |=> tx_clock_lost)
    else $error("transmit clock loss not flagged");

  cond_edges_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ($rose(rx_carrier_lost_i) or $fell(tx_open_circuit_i))
      |-> ##1 (status.rx_carrier_lost || status.tx_open_circuit))
    else $error("condition edge not latched");

  read_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (rd_status && !jitter_fifo_near_limit_i) |=> !status.jitter_fifo_near_limit)
    else $error("jitter event not cleared by read");

  set_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (|(sig_change_i & sig_change_enable_i)) |=> status.signaling_change_event)
    else $error("signaling change lost");

  timer_tick_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    timer_hit |=> (status.timer_event && tmr_cnt == 21'h000000))
    else $error("timer event missing at interval end");

  input_below_threshold_delay_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(input_below_threshold_cond) |-> ($past(input_below_threshold_cnt) == INPUT_BELOW_THRESHOLD_CYC - 23'h000001))
    else $error("under-threshold set too early");

  irq_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ((|(status & mask)) && $stable(mask)) |-> !int_n_o)
    else $error("interrupt not asserted for unmasked status");

endmodule : lisi_top

// >>> lisi_line_model.sv
// line-side model: transmit clock source and receive bit ticks
`timescale 1ns/1ps
module lisi_line_model #(
  parameter int TICK_CYC = 4
)
(
  input wire logic core_clk_i, // core clock
  input wire logic tx_clk_run_i, // 1 lets the transmit clock toggle
  output logic liu_tx_clock_o, // transmit clock toward the block
  output logic rx_bit_tick_o // one pulse per receive bit
);
  int cnt = 0;
  initial liu_tx_clock_o = 1'b0;
  initial rx_bit_tick_o = 1'b0;
  // outputs move on the falling edge so the block never samples them mid-change
  always @(negedge core_clk_i)
  begin
    cnt <= (cnt + 1) % TICK_CYC;
    rx_bit_tick_o <= (cnt == 0);
    if (tx_clk_run_i && cnt == 0)
      liu_tx_clock_o <= ~liu_tx_clock_o; // a stopped clock holds its level
  end
endmodule : lisi_line_model

// >>> tb_top.sv
// self-checking bench for the line status and interrupt block
`timescale 1ns/1ps
module tb_top;
  import lisi_pkg::*;
  localparam int TICK = 4;
  // rows: gain limit, standard, raw level, open, limit, bitcode, expected info
  localparam logic [16:0] ROWS [6] = '{{1'b0, 1'b0, 4'h9, 3'b000, 8'h09},
    {1'b1, 1'b0, 4'h9, 3'b000, 8'h05}, {1'b1, 1'b0, 4'h3, 3'b100, 8'h13},
    {1'b1, 1'b1, 4'hf, 3'b010, 8'h2f}, {1'b0, 1'b0, 4'h0, 3'b001, 8'h40},
    {1'b1, 1'b0, 4'h5, 3'b111, 8'h75}};
  localparam logic [7:0] SBIT [3] = '{8'h02, 8'h04, 8'h08};
  localparam int TMR [4] = '{40, 20, 60, 30};
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic int_n_o;
  lisi_cfg_t cfg_i = '0;
  logic [3:0] rx_level_raw_i = 4'h0;
  logic [2:0] cond = 3'b000;
  logic bc = 1'b0;
  logic jit = 1'b0;
  logic bv = 1'b0;
  logic be = 1'b0;
  logic tx_run = 1'b1;
  logic tx_clk;
  logic tick;
  logic [31:0] sig_chg = '0;
  logic [31:0] sig_en = '0;
  logic [7:0] v;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  int ev [3];
  int n;

  lisi_line_model #(.TICK_CYC(TICK)) u_line (.core_clk_i(core_clk_i),
    .tx_clk_run_i(tx_run), .liu_tx_clock_o(tx_clk), .rx_bit_tick_o(tick));

  // short counts keep the run brief; expectations derive from these values
  lisi_top #(.INPUT_BELOW_THRESHOLD_CYC(23'd50), .T1_LONG_TICKS(21'd40), .T1_SHORT_TICKS(21'd20),
    .E1_LONG_TICKS(21'd60), .E1_SHORT_TICKS(21'd30)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .rd_i(rd_i),
    .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .int_n_o(int_n_o),
    .cfg_i(cfg_i), .rx_level_raw_i(rx_level_raw_i), .tx_open_circuit_i(cond[0]),
    .tx_current_limit_hit_i(cond[1]), .bitcode_seen_i(bc), .bert_bit_valid_i(bv),
    .bert_bit_err_i(be), .liu_tx_clock_in_i(tx_clk), .rx_carrier_lost_i(cond[2]),
    .jitter_fifo_near_limit_i(jit), .rx_bit_tick_i(tick), .sig_change_i(sig_chg),
    .sig_change_enable_i(sig_en));

  // clock and cycle count
  initial forever #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) cyc <= cyc + 1;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic wait_n(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask : wait_n

  // strobes open a cycle after the previous access so they never re-assert at once
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge core_clk_i);
    rd_i = 1'b0;
    d = rdata_o;
  endtask : reg_rd

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge core_clk_i);
    wr_i = 1'b0;
  endtask : reg_wr

  task automatic send_bits(input int k, input logic e);
    repeat (k)
    begin
      @(negedge core_clk_i);
      bv = 1'b1;
      be = e;
      @(negedge core_clk_i);
      bv = 1'b0;
    end
    wait_n(3);
    reg_rd(LISI_OFS_INFO, v);
  endtask : send_bits

  initial
  begin
    wait_n(20);
    rst_n_i = 1'b1;
    reg_rd(LISI_OFS_INFO, v);
    chk(v, LISI_INFO_RST, "info reset");
    reg_rd(LISI_OFS_MASK, v);
    chk(v, LISI_MASK_RST, "mask reset");
    chk({7'h0, int_n_o}, 8'h01, "int idle");
    for (int i = 0; i < 6; i++)
    begin
      {cfg_i.eq_gain_limit, cfg_i.line_standard_select, rx_level_raw_i, cond[0], cond[1], bc} = ROWS[i][16:8];
      wait_n(3);
      reg_rd(LISI_OFS_INFO, v);
      chk(v, ROWS[i][7:0], "info row");
    end
    cfg_i = '0;
    rx_level_raw_i = 4'h0;
    cond = 3'b000;
    bc = 1'b0;
    reg_wr(LISI_OFS_MASK, 8'ha5);
    reg_rd(LISI_OFS_MASK, v);
    chk(v, 8'ha5, "mask readback");
    reg_wr(LISI_OFS_INFO, 8'hff);
    reg_rd(LISI_OFS_INFO, v);
    chk(v, 8'h00, "info read only");
    reg_rd(8'h20, v);
    chk(v, LISI_UNMAPPED_RD, "unmapped read");
    // each condition must latch on both edges and drive the interrupt
    for (int b = 0; b < 3; b++)
    begin
      reg_wr(LISI_OFS_MASK, SBIT[b]);
      reg_rd(LISI_OFS_STATUS, v);
      cond[b] = 1'b1;
      wait_n(3);
      chk({7'h0, int_n_o}, 8'h00, "int on rise");
      reg_rd(LISI_OFS_STATUS, v);
      chk(v & SBIT[b], SBIT[b], "rise latched");
      wait_n(2);
      chk({7'h0, int_n_o}, 8'h01, "int released");
      cond[b] = 1'b0;
      wait_n(3);
      reg_rd(LISI_OFS_STATUS, v);
      chk(v & SBIT[b], SBIT[b], "fall latched");
    end
    reg_wr(LISI_OFS_MASK, 8'h00);
    reg_rd(LISI_OFS_STATUS, v);
    jit = 1'b1;
    sig_en = 32'h8;
    sig_chg = 32'h10;
    wait_n(1);
    jit = 1'b0;
    sig_chg = 32'h0;
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h30, 8'h10, "jitter set, disabled channel ignored");
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h10, 8'h00, "jitter cleared by read");
    sig_chg = 32'h8;
    wait_n(1);
    sig_chg = '0;
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h20, 8'h20, "signaling change");
    // under-threshold needs the level to stay weak for the whole span
    cfg_i.level_threshold = 4'h4;
    rx_level_raw_i = 4'h8;
    wait_n(28);
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h80, 8'h00, "under threshold early");
    wait_n(30);
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h80, 8'h80, "under threshold set");
    rx_level_raw_i = 4'h0;
    tx_run = 1'b0;
    wait_n(498);
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h01, 8'h00, "tx clock quiet early");
    wait_n(40);
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h01, 8'h01, "tx clock lost");
    tx_run = 1'b1;
    wait_n(10);
    reg_rd(LISI_OFS_STATUS, v);
    chk(v & 8'h01, 8'h01, "tx clock back");
    // timer period in each standard and interval choice
    for (int m = 0; m < 4; m++)
    begin
      {cfg_i.line_standard_select, cfg_i.counter_interval_select} = 2'(m);
      n = 0;
      for (int k = 0; k < 2000 && n < 3; k++)
      begin
        reg_rd(LISI_OFS_STATUS, v);
        if (v[6] === 1'b1)
        begin
          ev[n] = cyc;
          n++;
        end
      end
      if (n < 3)
      begin
        mismatches++;
        results();
      end
      chk(8'(ev[2] - ev[1]), 8'(TMR[m] * TICK), "timer period");
    end
    send_bits(31, 1'b0);
    chk(v & 8'h80, 8'h00, "no sync at 31");
    send_bits(1, 1'b0);
    chk(v & 8'h80, 8'h80, "sync at 32");
    send_bits(5, 1'b1);
    chk(v & 8'h80, 8'h80, "sync holds at 5 errors");
    send_bits(1, 1'b1);
    chk(v & 8'h80, 8'h00, "sync lost at 6 errors");
    results();
  end
endmodule : tb_top
